/* rtl/dcf_top.sv */
// per-channel sinc3 / sinc3+sinc1 decimation with dc-block output stage
`timescale 1ns/100ps
`include "dcf_regs.svh"
module dcf_top (
    // clock and reset
    input  wire logic             CLK_I,
    input  wire logic             RST_N_I,
    // modulator bitstreams, one per channel
    input  wire logic [3:0]       MOD_BIT_I,
    // configuration
    input  wire logic [3:0]       OSR_SEL_I,
    input  wire logic [3:0]       CHAN_ENABLE_I,
    input  wire logic [3:0]       CHAN_RECONFIG_I,
    input  wire logic             RESYNC_I,
    input  wire logic [3:0]       HIGHPASS_COEFF_SELECT_I,
    input  wire logic [3:0]       CHAN_HIGHPASS_DISABLE_I,
    // status
    output logic [15:0]           SETTLE_TIME_O,
    output logic                  CONVERSION_READY_N_O,
    output logic                  OVERRUN_O,
    // conversion stream
    output logic                  OUT_VALID_O,
    input  wire logic             OUT_READY_I,
    output dcf_pkg::dcf_word_type OUT_WORD_O
);
    // ************************************************************
    // declarations
    // ************************************************************
    localparam dcf_pkg::dcf_core_type ST_RST = '{ready_n: 1'b1, default: '0};

    dcf_pkg::dcf_core_type st, nx;
    dcf_pkg::dcf_word_type push_word;
    logic [3:0]            code;
    logic [3:0]            k3;
    logic [3:0]            m1;
    logic [4:0]            log_n;
    logic [4:0]            log3;
    logic [4:0]            sh3;
    logic [13:0]           mask3;
    logic [13:0]           last;
    logic                  cascade;
    logic                  dec3;
    logic                  conv;
    logic                  glob_restart;
    logic [3:0]            restart;
    logic [3:0]            take_mask;
    logic [3:0][31:0]      c0;
    logic [3:0][31:0]      c1;
    logic [3:0][31:0]      c2;
    logic [3:0][27:0]      tot;
    logic [3:0][23:0]      s3;
    logic [3:0][23:0]      fast;
    logic [3:0][23:0]      avg;
    logic [3:0][23:0]      res;
    logic [1:0]            sel;
    logic                  push;
    logic                  in_ready;
    logic                  bypass;
    logic [23:0]           hp_y;

    // ************************************************************
    // scaling
    // ************************************************************
    // brings a filter sum of gain 2^sh to a 24-bit full-scale word
    function automatic logic [23:0] sat_scale(input logic [31:0] y, input logic [4:0] sh);
        logic signed [63:0] w;
        w = $signed({{32{y[31]}}, y});
        w = w <<< `DCF_SCALE;
        w = w >>> sh;
        if (w > `DCF_POS_MAX) begin
            sat_scale = 24'h7fffff;
        end else if (w < `DCF_NEG_MIN) begin
            sat_scale = 24'h800000;
        end else begin
            sat_scale = w[23:0];
        end
    endfunction : sat_scale

    // ************************************************************
    // ratio decode
    // ************************************************************
    // codes above the largest ratio are clamped, never left undefined
    assign code    = (OSR_SEL_I > `DCF_CODE_MAX) ? `DCF_CODE_MAX : OSR_SEL_I;
    assign k3      = (code > `DCF_CODE_S3MAX) ? `DCF_CODE_S3MAX : code;
    assign m1      = code - k3;
    assign cascade = (m1 != 4'h0);
    assign log_n   = `DCF_LOG_BASE + {1'b0, code};
    assign log3    = `DCF_LOG_BASE + {1'b0, k3};
    assign sh3     = 5'({log3, 1'b0} + {1'b0, log3});
    assign mask3   = 14'((15'h0001 << log3) - 15'h0001);
    assign last    = 14'((15'h0001 << log_n) - 15'h0001);

    // phase runs at the modulator rate only, on every second clock
    assign dec3 = st.div && ((st.phase & mask3) == mask3);
    assign conv = st.div && (st.phase == last);

    // ************************************************************
    // restart triggers
    // ************************************************************
    assign glob_restart = RESYNC_I || (code != st.oversampling_ratio);
    assign restart      = {4{glob_restart}} | CHAN_RECONFIG_I
                        | (CHAN_ENABLE_I & ~st.en) | ~CHAN_ENABLE_I;

    // ************************************************************
    // per-channel combs and output selection
    // ************************************************************
    for (genvar g = 0; g < 4; g++) begin : g_chan
        // combs see the pre-tick integrator, so all three stay aligned
        assign c0[g]   = st.integ[g][2] - st.dly[g][0];
        assign c1[g]   = c0[g] - st.dly[g][1];
        assign c2[g]   = c1[g] - st.dly[g][2];
        assign s3[g]   = sat_scale(c2[g], sh3);
        assign fast[g] = sat_scale(st.integ[g][0] - st.fprev[g], log_n);
        assign tot[g]  = st.sacc[g] + {{4{s3[g][23]}}, s3[g]};
        assign avg[g]  = 24'($signed(tot[g]) >>> m1);
        assign res[g]  = (st.fast_cnt < `DCF_FAST_CONVS) ? fast[g]
                       : (cascade ? avg[g] : s3[g]);
    end

    // ************************************************************
    // word pusher
    // ************************************************************
    always_comb begin
        sel = 2'h0;
        for (int i = 3; i >= 0; i--) begin
            if (st.pend[i]) begin
                sel = 2'(i);
            end
        end
    end

    assign push      = (st.pend != 4'h0);
    assign bypass    = (HIGHPASS_COEFF_SELECT_I == `DCF_HP_OFF)
                    || CHAN_HIGHPASS_DISABLE_I[sel];
    assign take_mask = (push && in_ready) ? (4'h1 << sel) : 4'h0;
    assign push_word = '{chan: sel, sample: hp_y};

    // ************************************************************
    // core next state
    // ************************************************************
    always_comb begin
        nx         = st;
        nx.div     = ~st.div;
        nx.oversampling_ratio     = code;
        nx.en      = CHAN_ENABLE_I;
        nx.ready_n = 1'b1;
        nx.overrun = 1'b0;
        case (code)
            4'h0:    nx.settle = `DCF_SETTLE_64;
            4'h1:    nx.settle = `DCF_SETTLE_128;
            4'h2:    nx.settle = `DCF_SETTLE_256;
            4'h3:    nx.settle = `DCF_SETTLE_512;
            4'h4:    nx.settle = `DCF_SETTLE_1024;
            4'h5:    nx.settle = `DCF_SETTLE_2048;
            4'h6:    nx.settle = `DCF_SETTLE_4096;
            4'h7:    nx.settle = `DCF_SETTLE_8192;
            default: nx.settle = `DCF_SETTLE_16384;
        endcase
        nx.pend = st.pend & ~take_mask;
        // ready falls once the whole set of words has left for the fifo
        if (push && (nx.pend == 4'h0)) begin
            nx.ready_n = 1'b0;
        end
        if (st.div) begin
            nx.phase = conv ? 14'h0 : st.phase + 14'h1;
        end
        if (conv && (st.fast_cnt < `DCF_FAST_CONVS)) begin
            nx.fast_cnt = st.fast_cnt + 2'h1;
        end
        if (conv) begin
            // an unsent word is overwritten; the reader was too slow
            nx.overrun = (nx.pend != 4'h0);
            nx.pend    = CHAN_ENABLE_I & st.en;
        end
        for (int i = 0; i < 4; i++) begin
            if (st.div) begin
                nx.integ[i][0] = st.integ[i][0] + (MOD_BIT_I[i] ? 32'h1 : 32'hffffffff);
                nx.integ[i][1] = st.integ[i][1] + st.integ[i][0];
                nx.integ[i][2] = st.integ[i][2] + st.integ[i][1];
            end
            if (dec3) begin
                nx.dly[i][0] = st.integ[i][2];
                nx.dly[i][1] = c0[i];
                nx.dly[i][2] = c1[i];
                nx.sacc[i]   = (cascade && !conv) ? tot[i] : 28'h0;
            end
            if (conv) begin
                nx.fprev[i] = st.integ[i][0];
                if (CHAN_ENABLE_I[i] && st.en[i]) begin
                    nx.word[i] = res[i];
                end
            end
            if (restart[i]) begin
                nx.integ[i] = '0;
                nx.dly[i]   = '0;
                nx.fprev[i] = '0;
                nx.sacc[i]  = '0;
            end
        end
        if (glob_restart) begin
            nx.phase = 14'h0;
        end
    end

    always_ff @(posedge CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            st <= ST_RST;
        end else begin
            st <= nx;
        end
    end

    // ************************************************************
    // outputs and submodules
    // ************************************************************
    assign SETTLE_TIME_O        = st.settle;
    assign CONVERSION_READY_N_O = st.ready_n;
    assign OVERRUN_O            = st.overrun;

    dcf_hpf u_hpf (
        .clk_i    (CLK_I),
        .rst_n_i  (RST_N_I),
        .take_i   (push && in_ready),
        .chan_i   (sel),
        .x_i      (st.word[sel]),
        .coeff_i  (HIGHPASS_COEFF_SELECT_I),
        .bypass_i (bypass),
        .y_o      (hp_y)
    );

    dcf_fifo #(
        .W ($bits(dcf_pkg::dcf_word_type)),
        .D (`DCF_FIFO_DEPTH)
    ) u_fifo (
        .clk_i       (CLK_I),
        .rst_n_i     (RST_N_I),
        .in_valid_i  (push),
        .in_ready_o  (in_ready),
        .in_data_i   (push_word),
        .out_valid_o (OUT_VALID_O),
        .out_ready_i (OUT_READY_I),
        .out_data_o  (OUT_WORD_O)
    );

    // ************************************************************
    // checks
    // ************************************************************
    mod_rate_a:
    assert property (@(posedge CLK_I) disable iff (!RST_N_I)
        (st.phase != $past(st.phase)) |-> ($past(st.div) || $past(glob_restart)))
    else $error("phase moved off the modulator rate");

    fast_count_a:
    assert property (@(posedge CLK_I) disable iff (!RST_N_I)
        (st.fast_cnt != $past(st.fast_cnt))
        |-> ($past(conv) && ($past(st.fast_cnt) < `DCF_FAST_CONVS)))
    else $error("fast conversion count moved wrongly");

    sinc3_word_a:
    assert property (@(posedge CLK_I) disable iff (!RST_N_I)
        (conv && (st.fast_cnt == `DCF_FAST_CONVS) && !cascade
         && CHAN_ENABLE_I[0] && st.en[0])
        |=> (st.word[0] == $past(s3[0])))
    else $error("sinc3 word not taken at conversion");

    fast_word_a:
    assert property (@(posedge CLK_I) disable iff (!RST_N_I)
        (conv && (st.fast_cnt < `DCF_FAST_CONVS) && CHAN_ENABLE_I[1] && st.en[1])
        |=> (st.word[1] == $past(fast[1])))
    else $error("first words not from the fast path");

    cascade_sum_a:
    assert property (@(posedge CLK_I) disable iff (!RST_N_I)
        (conv && cascade && (st.fast_cnt == `DCF_FAST_CONVS)
         && CHAN_ENABLE_I[2] && st.en[2])
        |=> (st.word[2] == $past(avg[2])) && (st.sacc[2] == 28'h0))
    else $error("sinc1 group did not close at conversion");

    restart_a:
    assert property (@(posedge CLK_I) disable iff (!RST_N_I)
        RESYNC_I |=> (st.phase == 14'h0) && (st.integ[3] == '0) && (st.sacc[3] == 28'h0))
    else $error("resync did not restart the chain");

    no_gate_a:
    assert property (@(posedge CLK_I) disable iff (!RST_N_I)
        conv |=> (st.pend == $past(CHAN_ENABLE_I & st.en)))
    else $error("conversion words were gated");

    ready_pulse_a:
    assert property (@(posedge CLK_I) disable iff (!RST_N_I)
        $fell(CONVERSION_READY_N_O)
        |-> ($past(st.pend) != 4'h0) ##1 CONVERSION_READY_N_O)
    else $error("ready low without a finished set");

    settle_tab_a:
    assert property (@(posedge CLK_I) disable iff (!RST_N_I)
        (OSR_SEL_I == 4'h0) |=> (SETTLE_TIME_O == `DCF_SETTLE_64))
    else $error("settling time table mismatch");

    settle_cas_a:
    assert property (@(posedge CLK_I) disable iff (!RST_N_I)
        (OSR_SEL_I == (`DCF_CODE_S3MAX + 4'h1)) |=> (SETTLE_TIME_O == `DCF_SETTLE_2048))
    else $error("cascade settling time mismatch");

    settle_max_a:
    assert property (@(posedge CLK_I) disable iff (!RST_N_I)
        (OSR_SEL_I >= `DCF_CODE_MAX) |=> (SETTLE_TIME_O == `DCF_SETTLE_16384))
    else $error("largest ratio settling time mismatch");

    // a ratio change may leave the old phase above the new end for one cycle
    phase_range_a:
    assert property (@(posedge CLK_I) disable iff (!RST_N_I)
        !glob_restart |-> (st.phase <= last))
    else $error("phase ran past the selected ratio");

    fast_hold_a:
    assert property (@(posedge CLK_I) disable iff (!RST_N_I)
        (st.fast_cnt == `DCF_FAST_CONVS) |=> (st.fast_cnt == `DCF_FAST_CONVS))
    else $error("fast path came back before reset");

    overrun_flag_a:
    assert property (@(posedge CLK_I) disable iff (!RST_N_I)
        OVERRUN_O |-> ($past(conv) && ($past(st.pend & ~take_mask) != 4'h0)))
    else $error("overrun flagged without a lost word");

    hp_off_a:
    assert property (@(posedge CLK_I) disable iff (!RST_N_I)
        (push && (HIGHPASS_COEFF_SELECT_I == `DCF_HP_OFF)) |-> (push_word.sample == st.word[sel]))
    else $error("word altered with the high-pass off");

    hp_chan_a:
    assert property (@(posedge CLK_I) disable iff (!RST_N_I)
        (push && CHAN_HIGHPASS_DISABLE_I[sel]) |-> (push_word.sample == st.word[sel]))
    else $error("disabled channel passed the high-pass");

    reconfig_clear_a:
    assert property (@(posedge CLK_I) disable iff (!RST_N_I)
        CHAN_RECONFIG_I[0] |=> (st.integ[0] == '0) && (st.sacc[0] == 28'h0))
    else $error("reconfigured channel did not restart");

    disabled_clear_a:
    assert property (@(posedge CLK_I) disable iff (!RST_N_I)
        !CHAN_ENABLE_I[1] |=> (st.integ[1] == '0) && (st.dly[1] == '0))
    else $error("disabled channel chain not held cleared");

    enable_rise_a:
    assert property (@(posedge CLK_I) disable iff (!RST_N_I)
        (CHAN_ENABLE_I[3] && !st.en[3]) |=> (st.integ[3] == '0))
    else $error("enabled channel did not restart");
endmodule : dcf_top

/* rtl/dcf_regs.svh */
// constants of the decimation and dc-block filter
// Contract
// - first two conversions use fast sinc1 path
// - modulator bit rate is master clock over two
// - sinc3 path from third conversion on
// - ratios 64 to 1024 decimate in sinc3
// - larger ratios: sinc3 at 1024, then sinc1
// - sinc3 is cubed normalised boxcar response
// - nulls at data rate multiples, repeat at modulator
// - enable, reconfig or resync restarts channel chain
// - unsettled words delivered like any other
// - first ready fall after settling is settled
// - sinc3 settling 728 to 2648 master clocks
// - cascade settling 4696 to 33368 master clocks
// - coefficient select zero disables the high-pass
// - per-channel disable bypasses the high-pass
// - high-pass coefficient is 2 to -(k+1)
// - high-pass settles within 88 to 1627730 samples
// - corner scales with clock and data rate
`ifndef DCF_REGS_SVH
`define DCF_REGS_SVH
`define DCF_CODE_MAX    4'h8
`define DCF_CODE_S3MAX  4'h4
`define DCF_LOG_BASE    5'h06
`define DCF_FAST_CONVS  2'h2
`define DCF_HP_OFF      4'h0
`define DCF_HP_FRAC     16
`define DCF_FIFO_DEPTH  16
`define DCF_SCALE       23
`define DCF_POS_MAX     64'sh00000000007fffff
`define DCF_NEG_MIN     64'shffffffffff800000
`define DCF_SETTLE_64    16'h02d8
`define DCF_SETTLE_128   16'h0358
`define DCF_SETTLE_256   16'h0458
`define DCF_SETTLE_512   16'h0658
`define DCF_SETTLE_1024  16'h0a58
`define DCF_SETTLE_2048  16'h1258
`define DCF_SETTLE_4096  16'h2258
`define DCF_SETTLE_8192  16'h4258
`define DCF_SETTLE_16384 16'h8258
`endif

/* rtl/dcf_pkg.sv */
// types of the decimation and dc-block filter
package dcf_pkg;
    typedef struct packed {
        logic [1:0]  chan;
        logic [23:0] sample;
    } dcf_word_type;
    typedef struct packed {
        logic                  div;
        logic [13:0]           phase;
        logic [1:0]            fast_cnt;
        logic [3:0]            oversampling_ratio;
        logic [3:0]            en;
        logic [3:0][2:0][31:0] integ;
        logic [3:0][2:0][31:0] dly;
        logic [3:0][31:0]      fprev;
        logic [3:0][27:0]      sacc;
        logic [3:0][23:0]      word;
        logic [3:0]            pend;
        logic                  ready_n;
        logic                  overrun;
        logic [15:0]           settle;
    } dcf_core_type;
    typedef struct packed {
        logic [3:0][39:0] est;
    } dcf_hpf_type;
endpackage : dcf_pkg

/* rtl/dcf_fifo.sv */
// word fifo between the filter core and the reader
`timescale 1ns/100ps
module dcf_fifo #(
    parameter int W = 26,
    parameter int D = 16
) (
    // clock and reset
    input  wire logic         clk_i,
    input  wire logic         rst_n_i,
    // fill side
    input  wire logic         in_valid_i,
    output logic              in_ready_o,
    input  wire logic [W-1:0] in_data_i,
    // drain side
    output logic              out_valid_o,
    input  wire logic         out_ready_i,
    output logic [W-1:0]      out_data_o
);
    typedef struct packed {
        logic [D-1:0][W-1:0]    mem;
        logic [$clog2(D)-1:0]   wr;
        logic [$clog2(D)-1:0]   rd;
        logic [$clog2(D):0]     cnt;
    } dcf_fifo_type;
    localparam logic [$clog2(D):0] FULL = ($clog2(D)+1)'(D);
    dcf_fifo_type st, nx;
    logic         push, pop;
    assign in_ready_o  = (st.cnt != FULL);
    assign out_valid_o = (st.cnt != '0);
    assign out_data_o  = st.mem[st.rd];
    assign push        = in_valid_i && in_ready_o;
    assign pop         = out_valid_o && out_ready_i;
    always_comb begin
        nx = st;
        if (push) begin
            nx.mem[st.wr] = in_data_i;
            nx.wr         = st.wr + 1'b1;
        end
        if (pop) begin
            nx.rd = st.rd + 1'b1;
        end
        nx.cnt = st.cnt + {{$clog2(D){1'b0}}, push} - {{$clog2(D){1'b0}}, pop};
    end
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st <= '0;
        end else begin
            st <= nx;
        end
    end
    fifo_full_a:
    assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (st.cnt == FULL && !pop) |=> (st.cnt == FULL) && !in_ready_o)
    else $error("fifo lost a full state");
endmodule : dcf_fifo

/* rtl/dcf_hpf.sv */
// first-order dc-blocking high-pass, one estimate per channel
`timescale 1ns/100ps
`include "dcf_regs.svh"
module dcf_hpf (
    // clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_n_i,
    // sample in
    input  wire logic        take_i,
    input  wire logic [1:0]  chan_i,
    input  wire logic [23:0] x_i,
    input  wire logic [3:0]  coeff_i,
    input  wire logic        bypass_i,
    // sample out
    output logic [23:0]      y_o
);
    dcf_pkg::dcf_hpf_type st, nx;
    logic signed [40:0] xs, est, err;
    logic signed [24:0] eint;
    logic [4:0]         shift;
    assign xs    = 41'($signed(x_i)) <<< `DCF_HP_FRAC;
    assign est   = $signed({st.est[chan_i][39], st.est[chan_i]});
    assign err   = xs - est;
    assign eint  = 25'(err >>> `DCF_HP_FRAC);
    assign shift = {1'b0, coeff_i} + 5'h01;
    // corner follows the sample rate, since the update runs once per word
    always_comb begin
        nx = st;
        if (take_i && !bypass_i) begin
            nx.est[chan_i] = 40'(est + (err >>> shift));
        end
    end
    always_comb begin
        if (bypass_i) begin
            y_o = x_i;
        end else if (eint > 25'sh07fffff) begin
            y_o = 24'h7fffff;
        end else if (eint < -25'sh0800000) begin
            y_o = 24'h800000;
        end else begin
            y_o = eint[23:0];
        end
    end
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st <= '0;
        end else begin
            st <= nx;
        end
    end
    hp_bypass_a:
    assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (coeff_i == `DCF_HP_OFF || bypass_i) |-> (y_o == x_i))
    else $error("bypassed high-pass altered the word");
    hp_hold_a:
    assert property (@(posedge clk_i) disable iff (!rst_n_i)
        !(take_i && !bypass_i) |=> (st.est == $past(st.est)))
    else $error("dc estimate moved without a sample");
endmodule : dcf_hpf

/* dv/dcf_partner.sv */
// modulator bitstream source and pacing reader for the filter bench
`timescale 1ns/100ps
module dcf_partner (
    // clock and reset
    input  wire logic       clk_i,
    input  wire logic       rst_n_i,
    // control from the bench
    input  wire logic [1:0] mode_i,
    input  wire logic       stall_i,
    // toward the filter
    output logic [3:0]      mod_bit_o,
    output logic            ready_o
);
    logic [1:0] ph;
    // one modulator bit per two master clocks
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) ph <= 2'h0;
        else ph <= ph + 2'h1;
    end
    // mode 0 all low, 1 all high, 2 alternating on every modulator bit
    assign mod_bit_o = (mode_i == 2'h2) ? {4{ph[1]}} : {4{mode_i[0]}};
    // the reader only paces draining; judging settled words is left to the bench
    assign ready_o = !stall_i;
endmodule : dcf_partner

/* dv/dcf_top_tb_top.sv */
// self-checking bench of the decimation and dc-block filter
`timescale 1ns/100ps
module dcf_top_tb_top;
    // ****
    // signals
    // ****
    logic                  clk_i = 1'b0;
    logic                  rst_n_i = 1'b0;
    logic [3:0]            mod_bit;
    logic [3:0]            osr_sel = 4'h0;
    logic [3:0]            chan_en = 4'hf;
    logic [3:0]            reconfig = 4'h0;
    logic                  resync = 1'b0;
    logic [3:0]            coeff = 4'h0;
    logic [3:0]            hp_dis = 4'h0;
    logic [1:0]            mode = 2'h2;
    logic                  stall = 1'b0;
    logic [15:0]           settle;
    logic                  rdy_n;
    logic                  ovr;
    logic                  valid;
    logic                  ready;
    dcf_pkg::dcf_word_type word;
    logic [23:0]           last [4];
    logic [15:0]           tbl [9] = '{16'h02d8, 16'h0358, 16'h0458, 16'h0658, 16'h0a58,
                                       16'h1258, 16'h2258, 16'h4258, 16'h8258};
    int err_total = 0;
    int checks = 0;
    int cyc = 0;
    int nrdy = 0;
    int per = 0;
    int last_rdy = 0;
    int novr = 0;
    int nw [4] = '{0, 0, 0, 0};
    int s0, s1, s3, e;
    logic [3:0] codes [4] = '{4'h5, 4'h4, 4'h2, 4'h0};

    always #5 clk_i = ~clk_i;

    dcf_top dut (
        .CLK_I(clk_i), .RST_N_I(rst_n_i), .MOD_BIT_I(mod_bit), .OSR_SEL_I(osr_sel),
        .CHAN_ENABLE_I(chan_en), .CHAN_RECONFIG_I(reconfig), .RESYNC_I(resync),
        .HIGHPASS_COEFF_SELECT_I(coeff), .CHAN_HIGHPASS_DISABLE_I(hp_dis),
        .SETTLE_TIME_O(settle), .CONVERSION_READY_N_O(rdy_n), .OVERRUN_O(ovr),
        .OUT_VALID_O(valid), .OUT_READY_I(ready), .OUT_WORD_O(word)
    );
    dcf_partner model (
        .clk_i(clk_i), .rst_n_i(rst_n_i), .mode_i(mode), .stall_i(stall),
        .mod_bit_o(mod_bit), .ready_o(ready)
    );

    // ****
    // stream monitor and hang guard
    // ****
    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 70000) begin
            err_total++;
            stop_test();
        end
        if (valid === 1'b1 && ready === 1'b1) begin
            nw[word.chan] <= nw[word.chan] + 1;
            last[word.chan] <= word.sample;
        end
        if (rdy_n === 1'b0) begin
            nrdy <= nrdy + 1;
            per <= cyc - last_rdy;
            last_rdy <= cyc;
        end
        if (ovr === 1'b1) novr <= novr + 1;
    end

    // ****
    // tasks
    // ****
    task automatic check(input logic [23:0] got, input logic [23:0] exp);
        checks++;
        if (got !== exp) begin
            err_total++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check

    task automatic step(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask : step

    // waits n ready pulses, then lets the fifo hand the set over
    task automatic conv(input int n);
        int t;
        t = nrdy + n;
        while (nrdy < t) @(posedge clk_i);
        step(8);
    endtask : conv

    task automatic stop_test();
        $display("checks=%0d err_total=%0d", checks, err_total);
        if (err_total == 0 && checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : stop_test

    // ****
    // tests
    // ****
    initial begin
        step(12);
        check({8'h00, settle}, 24'h000000);
        check({22'h000000, rdy_n, valid}, 24'h000002);
        rst_n_i = 1'b1;
        $display("reset test done");
        for (int k = 0; k < 10; k++) begin
            osr_sel = (k == 9) ? 4'hf : k[3:0];
            step(3);
            check({8'h00, settle}, {8'h00, tbl[(k == 9) ? 8 : k]});
        end
        $display("settling table test done");
        // conversion cadence is twice the overall ratio in master clocks
        for (int k = 0; k < 4; k++) begin
            osr_sel = codes[k];
            conv(3);
            e = 128 << codes[k];
            check(per[23:0], e[23:0]);
        end
        conv(8);
        for (int c = 0; c < 4; c++) check(last[c], 24'h000000);
        $display("cadence and null test done");
        s0 = nw[0] + nw[1] + nw[2] + nw[3];
        mode = 2'h1;
        conv(8);
        for (int c = 0; c < 4; c++) check(last[c], 24'h7fffff);
        e = nw[0] + nw[1] + nw[2] + nw[3] - s0;
        check(e[23:0], 24'h000020);
        mode = 2'h0;
        conv(8);
        for (int c = 0; c < 4; c++) check(last[c], 24'h800000);
        $display("full scale test done");
        chan_en = 4'h5;
        conv(1);
        s0 = nw[0];
        s1 = nw[1];
        s3 = nw[3];
        reconfig = 4'h1;
        step(1);
        reconfig = 4'h0;
        conv(2);
        resync = 1'b1;
        step(1);
        resync = 1'b0;
        conv(2);
        e = nw[0] - s0;
        check(e[23:0], 24'h000004);
        check(nw[1][23:0], s1[23:0]);
        check(nw[3][23:0], s3[23:0]);
        chan_en = 4'hf;
        $display("enable and restart test done");
        mode = 2'h1;
        coeff = 4'h1;
        hp_dis = 4'h4;
        conv(120);
        check({23'h000000, $signed(last[0]) < 24'sh000400 && $signed(last[0]) > -24'sh000400},
              24'h000001);
        check(last[2], 24'h7fffff);
        coeff = 4'h0;
        conv(2);
        check(last[0], 24'h7fffff);
        $display("high-pass test done");
        // a stalled reader fills the fifo, later sets overwrite and flag it
        // ready pulses stop once the fifo is full, so wait seven conversions by time
        stall = 1'b1;
        step(900);
        check({23'h000000, valid}, 24'h000001);
        check({23'h000000, novr > 0}, 24'h000001);
        stall = 1'b0;
        for (int i = 0; i < 40 && valid === 1'b1; i++) step(1);
        check({23'h000000, valid}, 24'h000000);
        $display("fifo test done");
        stop_test();
    end
endmodule : dcf_top_tb_top
